// ---- rtl/das_regs.svh ----
/*
 * Register offsets, reset values and timing counts of the drive
 * application supervisor. Assumes 16-bit parameter words addressed by
 * their Modbus parameter address.
 */
`ifndef DAS_REGS_SVH
`define DAS_REGS_SVH

`define DAS_ADDR_SLEEP_STATUS   16'h0041
`define DAS_ADDR_KEY_CFG        16'h0602
`define DAS_ADDR_SLEEP_ENABLE   16'h0603
`define DAS_ADDR_WAKE_DIR       16'h0604
`define DAS_ADDR_SLEEP_LEVEL    16'h0700
`define DAS_ADDR_SLEEP_DELAY    16'h0701
`define DAS_ADDR_WAKE_LEVEL     16'h0702
`define DAS_ADDR_WAKE_DELAY     16'h0703
`define DAS_ADDR_LOSS_LEVEL     16'h0800
`define DAS_ADDR_LOSS_TIME      16'h0801
`define DAS_ADDR_LOSS_ACTION    16'h0802

`define DAS_RST_KEY_CFG         16'h0000
`define DAS_RST_SLEEP_ENABLE    16'h0000
`define DAS_RST_WAKE_DIR        16'h0001
`define DAS_RST_SLEEP_LEVEL     16'h0000
`define DAS_RST_SLEEP_DELAY     16'h000A
`define DAS_RST_WAKE_LEVEL      16'h0000
`define DAS_RST_WAKE_DELAY      16'h000A
`define DAS_RST_LOSS_LEVEL      16'h001E
`define DAS_RST_LOSS_TIME       16'h0032
`define DAS_RST_LOSS_ACTION     16'h0000

`define DAS_KEY_REMOTE_EN       16'h0000
`define DAS_KEY_JOG             16'h0001
`define DAS_WAKE_ABOVE          16'h0000
`define DAS_SRC_KEYPAD          4'h0
`define DAS_IN_FUNC_SLEEP       7'h21
`define DAS_OUT_FUNC_LOSS       7'h18
`define DAS_OUT_FUNC_SLEEP      7'h1B
`define DAS_AUX_FUNC_LOSS       5'h10
`define DAS_ACTION_ALARM        16'h0001
`define DAS_ACTION_FAULT        16'h0002

`define DAS_CLOCK_PERIOD_NS     8
`define DAS_TICK_NS             100000000
`define DAS_TICK_W              24

`endif

// ---- rtl/das_pkg.sv ----
/*
 * Types of the drive application supervisor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package das_pkg;
    typedef logic [15:0] das_word_t;
    typedef enum logic {
        DAS_AWAKE,
        DAS_ASLEEP
    } das_sleep_state_t;
endpackage

// ---- rtl/das_supervisor.sv ----
/*
 * Drive application supervisor: local/remote key, PID sleep and wakeup,
 * load-loss detection, with the parameter words behind a parameter port.
 * Assumes one 125 MHz clock, a synchronous active-low reset, levels from
 * the drive core on the same clock and raw key and input pins.
 */
`include "das_regs.svh"

module das_supervisor #(
    parameter int TICK_CYCLES = `DAS_TICK_NS / `DAS_CLOCK_PERIOD_NS
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_reg_wr,
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    input wire logic i_drive_running,
    input wire logic [3:0] i_run_source_select,
    input wire logic [3:0] i_freq_source_select,
    input wire logic [3:0] i_pid_enable_select,
    input wire logic [15:0] i_min_output_frequency,
    input wire logic [3:0][6:0] i_input_func_select,
    input wire logic [2:0][6:0] i_output_func_select,
    input wire logic [4:0] i_aux_analog_func_select,
    input wire logic [15:0] i_aux_loss_level,
    input wire logic [15:0] i_pid_output,
    input wire logic [15:0] i_pid_feedback,
    input wire logic [15:0] i_output_current,
    input wire logic i_key_pin,
    input wire logic [3:0] i_digital_in_pin,
    output logic o_remote_mode,
    output logic [3:0] o_run_source,
    output logic [3:0] o_freq_source,
    output logic o_sequence_led,
    output logic o_reference_led,
    output logic o_jog_request,
    output logic o_sleep_active,
    output logic o_pid_integral_clear,
    output logic o_sleep_setting_error,
    output logic o_di_sleep_setting_error,
    output logic [2:0] o_func_output,
    output logic o_load_loss_detected,
    output logic o_load_loss_alarm,
    output logic o_load_loss_fault
);
    // Parameter registers
    das_pkg::das_word_t key_cfg_q, key_cfg_d;
    das_pkg::das_word_t sleep_en_q, sleep_en_d;
    das_pkg::das_word_t wake_dir_q, wake_dir_d;
    das_pkg::das_word_t sleep_lvl_q, sleep_lvl_d;
    das_pkg::das_word_t sleep_dly_q, sleep_dly_d;
    das_pkg::das_word_t wake_lvl_q, wake_lvl_d;
    das_pkg::das_word_t wake_dly_q, wake_dly_d;
    das_pkg::das_word_t loss_lvl_q, loss_lvl_d;
    das_pkg::das_word_t loss_time_q, loss_time_d;
    das_pkg::das_word_t loss_act_q, loss_act_d;
    das_pkg::das_word_t rdata_d;

    // Parameters not changeable in operation refuse writes while running
    always_comb begin
        key_cfg_d = key_cfg_q;
        sleep_en_d = sleep_en_q;
        wake_dir_d = wake_dir_q;
        sleep_lvl_d = sleep_lvl_q;
        sleep_dly_d = sleep_dly_q;
        wake_lvl_d = wake_lvl_q;
        wake_dly_d = wake_dly_q;
        loss_lvl_d = loss_lvl_q;
        loss_time_d = loss_time_q;
        loss_act_d = loss_act_q;
        if (i_reg_wr) begin
            case (i_reg_addr)
                `DAS_ADDR_SLEEP_LEVEL: sleep_lvl_d = i_reg_wdata;
                `DAS_ADDR_SLEEP_DELAY: sleep_dly_d = i_reg_wdata;
                `DAS_ADDR_WAKE_LEVEL: wake_lvl_d = i_reg_wdata;
                `DAS_ADDR_WAKE_DELAY: wake_dly_d = i_reg_wdata;
                default: begin
                end
            endcase
            if (!i_drive_running) begin
                case (i_reg_addr)
                    `DAS_ADDR_KEY_CFG: key_cfg_d = i_reg_wdata;
                    `DAS_ADDR_SLEEP_ENABLE: sleep_en_d = i_reg_wdata;
                    `DAS_ADDR_WAKE_DIR: wake_dir_d = i_reg_wdata;
                    `DAS_ADDR_LOSS_LEVEL: loss_lvl_d = i_reg_wdata;
                    `DAS_ADDR_LOSS_TIME: loss_time_d = i_reg_wdata;
                    `DAS_ADDR_LOSS_ACTION: loss_act_d = i_reg_wdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            key_cfg_q <= `DAS_RST_KEY_CFG;
            sleep_en_q <= `DAS_RST_SLEEP_ENABLE;
            wake_dir_q <= `DAS_RST_WAKE_DIR;
            sleep_lvl_q <= `DAS_RST_SLEEP_LEVEL;
            sleep_dly_q <= `DAS_RST_SLEEP_DELAY;
            wake_lvl_q <= `DAS_RST_WAKE_LEVEL;
            wake_dly_q <= `DAS_RST_WAKE_DELAY;
            loss_lvl_q <= `DAS_RST_LOSS_LEVEL;
            loss_time_q <= `DAS_RST_LOSS_TIME;
            loss_act_q <= `DAS_RST_LOSS_ACTION;
            o_reg_rdata <= 16'h0000;
        end else begin
            key_cfg_q <= key_cfg_d;
            sleep_en_q <= sleep_en_d;
            wake_dir_q <= wake_dir_d;
            sleep_lvl_q <= sleep_lvl_d;
            sleep_dly_q <= sleep_dly_d;
            wake_lvl_q <= wake_lvl_d;
            wake_dly_q <= wake_dly_d;
            loss_lvl_q <= loss_lvl_d;
            loss_time_q <= loss_time_d;
            loss_act_q <= loss_act_d;
            o_reg_rdata <= rdata_d;
        end
    end

    // Pin synchronisers; stage one feeds stage two only
    logic [4:0] pin_meta_q, pin_sync_q;
    logic key_prev_q;
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
            key_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= {i_digital_in_pin, i_key_pin};
            pin_sync_q <= pin_meta_q;
            key_prev_q <= pin_sync_q[0];
        end
    end

    // Local/remote key and jog
    logic remote_q, remote_d, seq_led_d, ref_led_d, jog_d, key_press;
    logic selectors_keypad;
    always_comb begin
        key_press = pin_sync_q[0] && !key_prev_q;
        selectors_keypad = (i_run_source_select == `DAS_SRC_KEYPAD) &&
            (i_freq_source_select == `DAS_SRC_KEYPAD);
        remote_d = remote_q;
        if (key_cfg_q == `DAS_KEY_REMOTE_EN && key_press &&
            !i_drive_running && !selectors_keypad) begin
            remote_d = !remote_q;
        end
        seq_led_d = remote_d && (i_run_source_select != `DAS_SRC_KEYPAD);
        ref_led_d = remote_d && (i_freq_source_select != `DAS_SRC_KEYPAD);
        jog_d = (key_cfg_q == `DAS_KEY_JOG) && pin_sync_q[0] &&
            !i_drive_running &&
            (i_run_source_select == `DAS_SRC_KEYPAD);
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            remote_q <= 1'b1;
            o_sequence_led <= 1'b0;
            o_reference_led <= 1'b0;
            o_jog_request <= 1'b0;
        end else begin
            remote_q <= remote_d;
            o_sequence_led <= seq_led_d;
            o_reference_led <= ref_led_d;
            o_jog_request <= jog_d;
        end
    end

    assign o_remote_mode = remote_q;
    // Local mode hands both sources to the keypad
    assign o_run_source = remote_q ? i_run_source_select : `DAS_SRC_KEYPAD;
    assign o_freq_source = remote_q ? i_freq_source_select
                                    : `DAS_SRC_KEYPAD;

    // Shared 0.1 s tick keeps the three delay timers coarse but cheap
    logic [`DAS_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic tick;
    always_comb begin
        tick = (tick_cnt_q == `DAS_TICK_W'(TICK_CYCLES - 1));
        tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
    end
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // Delay timers: 0 sleep start, 1 wakeup, 2 load loss
    logic [2:0] tmr_cond, tmr_done;
    das_pkg::das_word_t tmr_limit [3];
    das_pkg::das_word_t tmr_cnt_q [3];
    das_pkg::das_word_t tmr_cnt_d [3];
    assign tmr_limit[0] = sleep_dly_q;
    assign tmr_limit[1] = wake_dly_q;
    assign tmr_limit[2] = loss_time_q;

    for (genvar k = 0; k < 3; k++) begin : g_tmr
        always_comb begin
            if (!tmr_cond[k]) begin
                tmr_cnt_d[k] = 16'h0000;
            end else if (tick && tmr_cnt_q[k] != 16'hFFFF) begin
                tmr_cnt_d[k] = tmr_cnt_q[k] + 16'h0001;
            end else begin
                tmr_cnt_d[k] = tmr_cnt_q[k];
            end
        end
        assign tmr_done[k] = tmr_cnt_q[k] > tmr_limit[k];
        always_ff @(posedge i_clock) begin
            if (!i_nrst) begin
                tmr_cnt_q[k] <= 16'h0000;
            end else begin
                tmr_cnt_q[k] <= tmr_cnt_d[k];
            end
        end
        a_timer_restart: assert property (@(posedge i_clock)
            disable iff (!i_nrst) !tmr_cond[k] |=> tmr_cnt_q[k] == 16'h0000)
            else $error("delay timer kept counting");
    end

    // Sleep and wakeup
    das_pkg::das_sleep_state_t state_q, state_d;
    logic [3:0] di_sleep_assigned;
    logic any_di_sleep, di_sleep_on, pid_on, sleep_on, sleep_allowed;
    logic wake_cond, sleep_err_d, di_err_d, sleep_run, wake_run;

    for (genvar n = 0; n < 4; n++) begin : g_di
        assign di_sleep_assigned[n] =
            (i_input_func_select[n] == `DAS_IN_FUNC_SLEEP);
    end

    always_comb begin
        any_di_sleep = |di_sleep_assigned;
        di_sleep_on = |(di_sleep_assigned & pin_sync_q[4:1]);
        pid_on = (i_pid_enable_select != 4'h0);
        sleep_on = (sleep_en_q != 16'h0000);
        sleep_err_d = !pid_on && (sleep_en_q == 16'h0001);
        di_err_d = any_di_sleep && (!pid_on || !sleep_on);
        sleep_allowed = pid_on && sleep_on &&
            !((sleep_lvl_q < i_min_output_frequency) && !any_di_sleep);
        wake_cond = (wake_dir_q == `DAS_WAKE_ABOVE) ?
            (i_pid_feedback > wake_lvl_q) :
            (i_pid_feedback < wake_lvl_q);
        sleep_run = sleep_allowed && state_q == das_pkg::DAS_AWAKE &&
            ((i_pid_output < sleep_lvl_q) || di_sleep_on);
        wake_run = state_q == das_pkg::DAS_ASLEEP && wake_cond;
        state_d = state_q;
        case (state_q)
            das_pkg::DAS_AWAKE: begin
                if (tmr_done[0]) begin
                    state_d = das_pkg::DAS_ASLEEP;
                end
            end
            das_pkg::DAS_ASLEEP: begin
                if (!sleep_allowed || tmr_done[1]) begin
                    state_d = das_pkg::DAS_AWAKE;
                end
            end
            default: state_d = das_pkg::DAS_AWAKE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state_q <= das_pkg::DAS_AWAKE;
            o_sleep_setting_error <= 1'b0;
            o_di_sleep_setting_error <= 1'b0;
        end else begin
            state_q <= state_d;
            o_sleep_setting_error <= sleep_err_d;
            o_di_sleep_setting_error <= di_err_d;
        end
    end

    assign o_sleep_active = (state_q == das_pkg::DAS_ASLEEP);
    assign o_pid_integral_clear = o_sleep_active;

    // Load loss
    das_pkg::das_word_t loss_level;
    logic loss_d, alarm_d, fault_d, loss_low;
    always_comb begin
        loss_level = (i_aux_analog_func_select == `DAS_AUX_FUNC_LOSS) ?
            i_aux_loss_level : loss_lvl_q;
        loss_low = i_drive_running &&
            (i_output_current < loss_level);
        loss_d = tmr_done[2];
        alarm_d = loss_d && (loss_act_q == `DAS_ACTION_ALARM);
        fault_d = o_load_loss_fault ||
            (loss_d && loss_act_q == `DAS_ACTION_FAULT);
    end
    // One driver for all three timer conditions
    assign tmr_cond = {loss_low, wake_run, sleep_run};

    // Fault latches until reset; the drive has shut down by then
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_load_loss_detected <= 1'b0;
            o_load_loss_alarm <= 1'b0;
            o_load_loss_fault <= 1'b0;
        end else begin
            o_load_loss_detected <= loss_d;
            o_load_loss_alarm <= alarm_d;
            o_load_loss_fault <= fault_d;
        end
    end

    for (genvar m = 0; m < 3; m++) begin : g_out
        assign o_func_output[m] =
            (i_output_func_select[m] == `DAS_OUT_FUNC_SLEEP &&
             o_sleep_active) ||
            (i_output_func_select[m] == `DAS_OUT_FUNC_LOSS &&
             o_load_loss_detected);
    end

    // Read port; unmapped addresses read zero
    always_comb begin
        case (i_reg_addr)
            `DAS_ADDR_SLEEP_STATUS: rdata_d = {15'h0000, o_sleep_active};
            `DAS_ADDR_KEY_CFG: rdata_d = key_cfg_q;
            `DAS_ADDR_SLEEP_ENABLE: rdata_d = sleep_en_q;
            `DAS_ADDR_WAKE_DIR: rdata_d = wake_dir_q;
            `DAS_ADDR_SLEEP_LEVEL: rdata_d = sleep_lvl_q;
            `DAS_ADDR_SLEEP_DELAY: rdata_d = sleep_dly_q;
            `DAS_ADDR_WAKE_LEVEL: rdata_d = wake_lvl_q;
            `DAS_ADDR_WAKE_DELAY: rdata_d = wake_dly_q;
            `DAS_ADDR_LOSS_LEVEL: rdata_d = loss_lvl_q;
            `DAS_ADDR_LOSS_TIME: rdata_d = loss_time_q;
            `DAS_ADDR_LOSS_ACTION: rdata_d = loss_act_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    a_remote_at_start: assert property (@(posedge i_clock)
        $rose(i_nrst) |-> o_remote_mode)
        else $error("not remote after reset");
    a_toggle_when_stopped: assert property (@(posedge i_clock)
        disable iff (!i_nrst) $changed(o_remote_mode) |->
        $past(!i_drive_running && key_cfg_q == `DAS_KEY_REMOTE_EN))
        else $error("toggle while running or key as jog");
    a_toggle_inhibit: assert property (@(posedge i_clock)
        disable iff (!i_nrst) $changed(o_remote_mode) |->
        $past(i_run_source_select != 4'h0 || i_freq_source_select != 4'h0))
        else $error("toggle with both selectors zero");
    a_local_leds_off: assert property (@(posedge i_clock)
        disable iff (!i_nrst) !o_remote_mode |->
        !o_sequence_led && !o_reference_led && o_run_source == 4'h0)
        else $error("local mode shows remote sources");
    a_jog_gate: assert property (@(posedge i_clock)
        disable iff (!i_nrst) o_jog_request |->
        $past(!i_drive_running && i_run_source_select == 4'h0))
        else $error("jog outside stop or keypad source");
    a_sleep_error: assert property (@(posedge i_clock)
        disable iff (!i_nrst)
        (i_pid_enable_select == 4'h0 && sleep_en_q == 16'h0001) |=>
        o_sleep_setting_error)
        else $error("sleep setting error missing");
    a_sleep_entry: assert property (@(posedge i_clock)
        disable iff (!i_nrst) $rose(o_sleep_active) |->
        $past(tmr_cnt_q[0] > sleep_dly_q))
        else $error("sleep entered before delay");
    a_wake_exit: assert property (@(posedge i_clock)
        disable iff (!i_nrst) $fell(o_sleep_active) && $past(sleep_allowed)
        |-> $past(tmr_cnt_q[1] > wake_dly_q))
        else $error("wakeup before delay");
    a_loss_fault: assert property (@(posedge i_clock)
        disable iff (!i_nrst) $rose(o_load_loss_fault) |->
        o_load_loss_detected && loss_act_q == `DAS_ACTION_FAULT)
        else $error("fault without fault action");

    c_remote_toggle: cover property (@(posedge i_clock)
        disable iff (!i_nrst) $fell(o_remote_mode));
    c_sleep_wake: cover property (@(posedge i_clock)
        disable iff (!i_nrst) $fell(o_sleep_active) && tmr_done[1]);
    c_loss_fault: cover property (@(posedge i_clock)
        disable iff (!i_nrst) $rose(o_load_loss_fault));
endmodule

// ---- bench/das_panel_model.sv ----
/*
 * Operator keypad and input terminal model for the supervisor bench.
 * Assumes requests from the bench change on the falling clock edge.
 */
module das_panel_model #(
    parameter int PRESS_CYCLES = 3
) (
    input wire logic i_clock,
    input wire logic i_press,
    input wire logic i_hold,
    input wire logic [3:0] i_din,
    output logic o_key_pin,
    output logic [3:0] o_digital_in_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // A tap must outlast the two-stage synchroniser
    // Rising edge sampling keeps clear of the bench's falling-edge drive
    always @(posedge i_clock) begin
        if (i_press) begin
            cnt <= PRESS_CYCLES;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign o_key_pin = i_hold || (cnt > 0);
    assign o_digital_in_pin = i_din;
endmodule

// ---- bench/testbench.sv ----
/*
 * Self-checking bench of the drive application supervisor.
 * Assumes das_supervisor with a shortened tick and the panel model.
 */
`include "das_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    logic clk = 0, nrst = 0, wr = 0, run = 0, press = 0, hold = 0;
    logic [15:0] addr = 0, wdata = 0, rdata, minf = 0, auxlvl = 0;
    logic [15:0] pido = 0, fb = 0, cur = 16'h00C8;
    logic [3:0] rsel = 1, fsel = 0, pid_en = 0, din = 0, dpins;
    logic [3:0][6:0] infs = '0;
    logic [2:0][6:0] outfs = '0;
    logic [4:0] auxf = 0;
    logic [3:0] rsrc, fsrc;
    logic [2:0] fout;
    logic key, remote, seq, ref_led, jog, slp, iclr, serr, dserr;
    logic ld, la, lf;
    int fails = 0, checked = 0, cycles = 0, n;
    integer seed = 32'hFDFD;

    das_supervisor #(.TICK_CYCLES(TK)) dut_u (.i_clock(clk),
        .i_nrst(nrst), .i_reg_wr(wr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_drive_running(run),
        .i_run_source_select(rsel), .i_freq_source_select(fsel),
        .i_pid_enable_select(pid_en), .i_min_output_frequency(minf),
        .i_input_func_select(infs), .i_output_func_select(outfs),
        .i_aux_analog_func_select(auxf), .i_aux_loss_level(auxlvl),
        .i_pid_output(pido), .i_pid_feedback(fb), .i_output_current(cur),
        .i_key_pin(key), .i_digital_in_pin(dpins), .o_remote_mode(remote),
        .o_run_source(rsrc), .o_freq_source(fsrc), .o_sequence_led(seq),
        .o_reference_led(ref_led), .o_jog_request(jog),
        .o_sleep_active(slp), .o_pid_integral_clear(iclr),
        .o_sleep_setting_error(serr), .o_di_sleep_setting_error(dserr),
        .o_func_output(fout), .o_load_loss_detected(ld),
        .o_load_loss_alarm(la), .o_load_loss_fault(lf));
    das_panel_model panel_u (.i_clock(clk), .i_press(press),
        .i_hold(hold), .i_din(din), .o_key_pin(key),
        .o_digital_in_pin(dpins));

    initial begin
        forever #4 clk = ~clk;
    end
    // Bench runs about 300 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wreg(input logic [15:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        cyc(1);
        wr = 0;
        // Idle edge so back-to-back writes never retoggle the strobe
        cyc(1);
    endtask
    task automatic rreg(input logic [15:0] a, input logic [15:0] e);
        addr = a;
        cyc(1);
        chk(rdata, e);
    endtask
    task automatic tap();
        press = 1;
        cyc(1);
        press = 0;
        cyc(8);
    endtask
    function automatic logic pick(input int w);
        return w ? ld : slp;
    endfunction
    // Bounded wait; a missed level shows as a mismatch
    task automatic waitv(input int w, input logic v, input int lim);
        n = 0;
        while (pick(w) !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk({15'h0, pick(w)}, {15'h0, v});
    endtask
    function automatic logic [1:0] loss_exp(input int a);
        return {a == 2, a == 1};
    endfunction

    initial begin
        cyc(12);
        nrst = 1;
        cyc(1);
        chk({15'h0, remote}, 16'h0001);
        rreg(`DAS_ADDR_KEY_CFG, 16'h0000);
        rreg(`DAS_ADDR_SLEEP_ENABLE, 16'h0000);
        rreg(`DAS_ADDR_WAKE_DIR, 16'h0001);
        rreg(`DAS_ADDR_LOSS_ACTION, 16'h0000);
        wreg(`DAS_ADDR_SLEEP_STATUS, 16'hFFFF);
        rreg(`DAS_ADDR_SLEEP_STATUS, 16'h0000);
        rreg(16'h0123, 16'h0000);
        rsel = 4'(($random(seed) & 7) + 1);
        cyc(2);
        chk({12'h0, rsrc}, {12'h0, rsel});
        chk({14'h0, seq, ref_led}, 16'h0002);
        tap();
        chk({14'h0, remote, seq}, 16'h0000);
        chk({8'h0, rsrc, fsrc}, 16'h0000);
        run = 1;
        tap();
        chk({15'h0, remote}, 16'h0000);
        run = 0;
        tap();
        chk({15'h0, remote}, 16'h0001);
        rsel = 0;
        tap();
        chk({15'h0, remote}, 16'h0001);
        fsel = 4'(($random(seed) & 7) + 1);
        wreg(`DAS_ADDR_KEY_CFG, 16'h0001);
        hold = 1;
        cyc(6);
        chk({14'h0, jog, remote}, 16'h0003);
        rsel = 3;
        cyc(5);
        chk({15'h0, jog}, 16'h0000);
        rsel = 0;
        run = 1;
        cyc(5);
        chk({15'h0, jog}, 16'h0000);
        run = 0;
        hold = 0;
        wreg(`DAS_ADDR_KEY_CFG, 16'h0000);
        wreg(`DAS_ADDR_SLEEP_LEVEL, 16'h1388);
        wreg(`DAS_ADDR_SLEEP_DELAY, 16'h0002);
        wreg(`DAS_ADDR_WAKE_DELAY, 16'h0002);
        wreg(`DAS_ADDR_WAKE_LEVEL, 16'h07D0);
        wreg(`DAS_ADDR_SLEEP_ENABLE, 16'h0001);
        infs[0] = `DAS_IN_FUNC_SLEEP;
        cyc(3);
        chk({14'h0, serr, dserr}, 16'h0003);
        pid_en = 1;
        pido = 16'h2710;
        cyc(3);
        chk({14'h0, serr, dserr}, 16'h0000);
        wreg(`DAS_ADDR_SLEEP_ENABLE, 16'h0000);
        cyc(2);
        chk({15'h0, dserr}, 16'h0001);
        wreg(`DAS_ADDR_SLEEP_ENABLE, 16'h0001);
        infs[0] = 0;
        outfs[1] = `DAS_OUT_FUNC_SLEEP;
        outfs[0] = `DAS_OUT_FUNC_LOSS;
        fb = 16'h2710;
        pido = 16'($unsigned($random(seed)) % 32'h1388);
        cyc(2 * TK);
        pido = 16'h2710;
        cyc(2);
        pido = 16'h0000;
        cyc(2 * TK);
        chk({15'h0, slp}, 16'h0000);
        waitv(0, 1'b1, 4 * TK);
        chk({13'h0, fout}, 16'h0002);
        chk({15'h0, iclr}, 16'h0001);
        rreg(`DAS_ADDR_SLEEP_STATUS, 16'h0001);
        pido = 16'h2710;
        fb = 16'h0064;
        cyc(2 * TK);
        chk({15'h0, slp}, 16'h0001);
        waitv(0, 1'b0, 4 * TK);
        chk({13'h0, fout}, 16'h0000);
        wreg(`DAS_ADDR_WAKE_DIR, 16'h0000);
        fb = 16'h0000;
        infs[2] = `DAS_IN_FUNC_SLEEP;
        din = 4'h4;
        waitv(0, 1'b1, 6 * TK);
        din = 0;
        fb = 16'h2710;
        waitv(0, 1'b0, 4 * TK);
        infs[2] = 0;
        minf = 16'h2000;
        pido = 0;
        cyc(6 * TK);
        chk({15'h0, slp}, 16'h0000);
        minf = 0;
        pido = 16'h2710;
        for (int a = 0; a < 3; a++) begin
            run = 0;
            cyc(2);
            wreg(`DAS_ADDR_LOSS_ACTION, 16'(a));
            wreg(`DAS_ADDR_LOSS_TIME, 16'h0002);
            auxf = (a == 2) ? `DAS_AUX_FUNC_LOSS : 5'h00;
            auxlvl = 16'h0050;
            cur = (a == 2) ? 16'h0040 : 16'($unsigned($random(seed)) % 30);
            run = 1;
            waitv(1, 1'b1, 4 * TK + 4);
            chk({14'h0, lf, la}, {14'h0, loss_exp(a)});
            chk({15'h0, fout[0]}, 16'h0001);
            wreg(`DAS_ADDR_LOSS_ACTION, 16'h0000);
            rreg(`DAS_ADDR_LOSS_ACTION, 16'(a));
            cur = 16'h00C8;
            cyc(3);
            chk({15'h0, ld}, 16'h0000);
        end
        conclude();
    end
endmodule
